// File: core/lcc_decoder.sv
// Contract
// - display timing outputs run before the drive supply is enabled.
// - accept an active-low logic-level reset from a processor or logic.
// - 010000 00 text home, 01 text area; executes in 32 oscillator periods.
// - 010000 10 graphic home, 11 graphic area; value from preceding parameters.
// - 1000 mode set; d3 char source, d2..d0 OR/EXOR/AND merge; 32 periods.
// - command/data select high addresses command register, low the data register.
// - reset input rests deasserted when nobody drives it.
`timescale 1ns/1ps
`default_nettype none
module lcc_decoder #(
  parameter int OSC_DIV   = 64,   // clk cycles per oscillator period
  parameter int LINE_LEN  = 30,   // shift clocks per line
  parameter int FRAME_LEN = 64    // lines per frame
) (
  clk,
  rst,
  reset_in_low,
  reset_in_oe,
  cd_sel,
  ce_n,
  rd_n,
  wr_n,
  db_in,
  db_out,
  db_oe,
  cfg,
  disp,
  timing_running,
  init_done,
  busy
);
  import lcc_pkg::*;
  input  wire logic          clk;
  input  wire logic          rst;
  input  wire logic          reset_in_low;
  input  wire logic          reset_in_oe;
  input  wire logic          cd_sel;
  input  wire logic          ce_n;
  input  wire logic          rd_n;
  input  wire logic          wr_n;
  input  wire logic [7:0]    db_in;
  output var  logic [7:0]    db_out;
  output var  logic          db_oe;
  output var  lcc_pkg::lcc_cfg_type  cfg;
  output var  lcc_pkg::lcc_disp_type disp;
  output var  logic          timing_running;
  output var  logic          init_done;
  output var  logic          busy;

  localparam int          EXEC_CLKS = EXEC_OSC_PERIODS * OSC_DIV;
  localparam int          PTR_CLKS  = PTR_OSC_PERIODS * OSC_DIV;
  localparam logic [15:0] EXEC_CNT  = 16'(EXEC_CLKS - 1);
  localparam logic [15:0] PTR_CNT   = 16'(PTR_CLKS - 1);

  // undriven reset pin floats high through the pull-up
  wire       res_pin = reset_in_oe ? reset_in_low : 1'b1;

  logic [12:0] sync_q;
  lcc_sync #(.W(13)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .rst_val (13'h1_e00),          // pins idle high: reset, ce, rd, wr
    .din     ({res_pin, ce_n, rd_n, wr_n, cd_sel, db_in}),
    .dout    (sync_q)
  );
  wire       res_s = sync_q[12];
  wire       ce_s  = sync_q[11];
  wire       rd_s  = sync_q[10];
  wire       wr_s  = sync_q[9];
  wire       cd_s  = sync_q[8];
  wire [7:0] dat_s = sync_q[7:0];

  // logic-level reset from the pin clears parameters, timer, configuration and panel timing; the oscillator divider keeps running
  wire dev_rst = !res_s;

  function automatic logic is_ptr(input logic [7:0] b);
    is_ptr = b[7:3] == PTR_SET_HI;
  endfunction : is_ptr
  function automatic logic is_ctrl(input logic [7:0] b);
    is_ctrl = b[7:2] == CTRL_SET_HI;
  endfunction : is_ctrl
  function automatic logic is_mode(input logic [7:0] b);
    is_mode = b[7:4] == MODE_SET_HI;
  endfunction : is_mode

  logic          wr_d_r;
  logic          ce_d_r;
  logic [7:0]    par0_r;
  logic [7:0]    par1_r;
  lcc_state_type state_r;
  logic [15:0]   exec_r;
  logic [4:0]    seen_r;
  logic [15:0]   osc_cnt_r;

  // write is taken on the trailing edge of the strobe while chip enabled
  wire wr_take  = wr_s && !wr_d_r && !ce_d_r;
  wire cmd_take = wr_take && cd_s && state_r == LCC_IDLE;
  wire dat_take = wr_take && !cd_s;
  wire [15:0] par_word = {par1_r, par0_r};
  wire osc_en   = osc_cnt_r == 16'(OSC_DIV - 1);

  wire ptr_hit  = cmd_take && is_ptr(dat_s);
  wire ctrl_hit = cmd_take && is_ctrl(dat_s);
  wire mode_hit = cmd_take && is_mode(dat_s);

  // oscillator enable divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      osc_cnt_r <= 16'h0000;
    else
      osc_cnt_r <= osc_en ? 16'h0000 : osc_cnt_r + 16'h0001;
  end

  // strobe edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_d_r <= 1'b1;
      ce_d_r <= 1'b1;
    end else begin
      wr_d_r <= wr_s;
      ce_d_r <= ce_s;
    end
  end

  // parameter bytes: the newest becomes the high byte, the older the low byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      par0_r <= 8'h00;
      par1_r <= 8'h00;
    end else if (dev_rst) begin
      par0_r <= 8'h00;
      par1_r <= 8'h00;
    end else if (dat_take) begin
      par0_r <= par1_r;
      par1_r <= dat_s;
    end
  end

  // execution timer; a command arriving while busy is ignored, host must poll
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= LCC_IDLE;
      exec_r  <= 16'h0000;
    end else if (dev_rst) begin
      state_r <= LCC_IDLE;
      exec_r  <= 16'h0000;
    end else begin
      unique case (state_r)
        LCC_IDLE: begin
          if (ptr_hit) begin
            state_r <= LCC_EXEC;
            exec_r  <= PTR_CNT;
          end else if (ctrl_hit || mode_hit) begin
            state_r <= LCC_EXEC;
            exec_r  <= EXEC_CNT;
          end
        end
        LCC_EXEC: begin
          if (exec_r == 16'h0000)
            state_r <= LCC_IDLE;
          else
            exec_r <= exec_r - 16'h0001;
        end
      endcase
    end
  end

  // command side effects on the configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg    <= '0;
      seen_r <= 5'h00;
    end else if (dev_rst) begin
      cfg    <= '0;
      seen_r <= 5'h00;
    end else if (ptr_hit) begin
      unique case (dat_s[2:0])
        PTR_CURSOR: cfg.cursor_ptr <= par_word;
        PTR_OFFSET: cfg.offset_reg <= par_word;
        PTR_ADDR:   cfg.addr_ptr   <= par_word;
        default:    cfg.addr_ptr   <= cfg.addr_ptr;  // undefined codes do nothing
      endcase
    end else if (ctrl_hit) begin
      seen_r[dat_s[1:0]] <= 1'b1;
      unique case (dat_s[1:0])
        CTRL_TXT_HOME: cfg.text_home <= par_word;
        CTRL_TXT_AREA: cfg.text_area <= par_word;
        CTRL_GFX_HOME: cfg.gfx_home  <= par_word;
        CTRL_GFX_AREA: cfg.gfx_area  <= par_word;
      endcase
    end else if (mode_hit) begin
      seen_r[4]                <= 1'b1;
      cfg.char_source_select   <= dat_s[CHAR_SRC_BIT];
      cfg.merge_mode           <= dat_s[2:0];
    end
  end

  // status answers command reads; data reads return zero in this block
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      db_out <= 8'h00;
      db_oe  <= 1'b0;
      busy   <= 1'b0;
      init_done <= 1'b0;
    end else begin
      db_oe  <= !ce_s && !rd_s && !dev_rst;
      db_out <= cd_s ? {6'h00, state_r == LCC_IDLE, state_r == LCC_IDLE} : 8'h00;
      busy   <= state_r == LCC_EXEC;
      init_done <= seen_r == INIT_ALL && !dev_rst;
    end
  end

  // panel timing: free-running from reset release, before any setup command
  logic [7:0] pix_r;
  logic [7:0] line_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_r  <= 8'h00;
      line_r <= 8'h00;
      disp   <= '0;
      timing_running <= 1'b0;
    end else if (dev_rst) begin
      pix_r  <= 8'h00;
      line_r <= 8'h00;
      disp   <= '0;
      timing_running <= 1'b0;
    end else if (osc_en) begin
      timing_running         <= 1'b1;
      disp.pixel_shift_clock <= !disp.pixel_shift_clock;
      if (disp.pixel_shift_clock) begin
        pix_r <= (pix_r == 8'(LINE_LEN - 1)) ? 8'h00 : pix_r + 8'h01;
        disp.line_latch_clock <= pix_r == 8'(LINE_LEN - 1);
        if (pix_r == 8'(LINE_LEN - 1)) begin
          line_r <= (line_r == 8'(FRAME_LEN - 1)) ? 8'h00 : line_r + 8'h01;
          disp.frame_start_marker <= line_r == 8'(FRAME_LEN - 1);
          if (line_r == 8'(FRAME_LEN - 1))
            disp.ac_drive <= !disp.ac_drive; // flips polarity each frame, no dc
        end
      end
    end
  end
endmodule : lcc_decoder
`default_nettype wire

// File: core/lcc_pkg.sv
package lcc_pkg;
  // command byte patterns
  localparam logic [4:0] PTR_SET_HI   = 5'h04;   // 00100 in d7..d3
  localparam logic [5:0] CTRL_SET_HI  = 6'h10;   // 010000 in d7..d2
  localparam logic [3:0] MODE_SET_HI  = 4'h8;    // 1000 in d7..d4
  localparam logic [2:0] PTR_CURSOR   = 3'h1;
  localparam logic [2:0] PTR_OFFSET   = 3'h2;
  localparam logic [2:0] PTR_ADDR     = 3'h4;
  localparam logic [1:0] CTRL_TXT_HOME = 2'h0;
  localparam logic [1:0] CTRL_TXT_AREA = 2'h1;
  localparam logic [1:0] CTRL_GFX_HOME = 2'h2;
  localparam logic [1:0] CTRL_GFX_AREA = 2'h3;
  localparam logic [2:0] MERGE_OR     = 3'h0;
  localparam logic [2:0] MERGE_EXOR   = 3'h1;
  localparam logic [2:0] MERGE_AND    = 3'h3;
  // field positions
  localparam int CHAR_SRC_BIT = 3;
  localparam int STA_CMD_BIT  = 0;
  localparam int STA_DATA_BIT = 1;
  // timing, in oscillator periods
  localparam int EXEC_OSC_PERIODS  = 32;
  localparam int PTR_OSC_PERIODS   = 1;
  localparam int RESET_OSC_PERIODS = 6;
  // reset values
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [2:0]  MERGE_RESET = 3'h0;
  // bit for each control word and the mode set seen since reset
  localparam logic [4:0]  INIT_ALL    = 5'h1f;

  typedef enum logic {LCC_IDLE, LCC_EXEC} lcc_state_type;

  typedef struct packed {
    logic [15:0] text_home;
    logic [15:0] text_area;
    logic [15:0] gfx_home;
    logic [15:0] gfx_area;
    logic [15:0] cursor_ptr;
    logic [15:0] offset_reg;
    logic [15:0] addr_ptr;
    logic        char_source_select;
    logic [2:0]  merge_mode;
  } lcc_cfg_type;

  typedef struct packed {
    logic ac_drive;
    logic line_latch_clock;
    logic pixel_shift_clock;
    logic frame_start_marker;
  } lcc_disp_type;
endpackage : lcc_pkg

// File: core/lcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; only stage two is visible outside
module lcc_sync #(
  parameter int W = 1
) (
  clk,
  rst,
  rst_val,
  din,
  dout
);
  input  wire logic         clk;
  input  wire logic         rst;
  input  wire logic [W-1:0] rst_val;
  input  wire logic [W-1:0] din;
  output var  logic [W-1:0] dout;

  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  // both stages keep the pins xor rst_val, so a cleared stage already reads as the
  // idle level; an all-zero output would fake a strobe edge right after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= din ^ rst_val;
      hold_r <= meta_r;
    end
  end

  // undo the idle-level encoding of stage two
  assign dout = hold_r ^ rst_val;
endmodule : lcc_sync
`default_nettype wire

// File: verif/lcc_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
// pin checks; busy spans are counted, far too long to unroll
module lcc_decoder_sva #(
  parameter int OSC_DIV = 64
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  reset_in_low,
  input wire logic                  reset_in_oe,
  input wire logic                  cd_sel,
  input wire logic                  ce_n,
  input wire logic                  rd_n,
  input wire logic [7:0]            db_out,
  input wire logic                  db_oe,
  input wire lcc_pkg::lcc_cfg_type  cfg,
  input wire lcc_pkg::lcc_disp_type disp,
  input wire logic                  timing_running,
  input wire logic                  init_done,
  input wire logic                  busy
);
  import lcc_pkg::*;
  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;
  wire         pin_hi = !reset_in_oe || reset_in_low;  // a floating pin reads high
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // length of the current busy run
  assign busy_cnt_nxt = busy ? busy_cnt_r + 16'h0001 : 16'h0000;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  sequence s_rd_strobe;
    (!ce_n && !rd_n) [*4];
  endsequence
  sequence s_idle_status;
    (cd_sel && pin_hi) [*6];
  endsequence
  a_exec_span_len: assert property (disable iff (rst || !pin_hi) $fell(busy) |->
    (busy_cnt_r - 16'(32 * OSC_DIV)) <= 16'h0001 || (busy_cnt_r - 16'(OSC_DIV)) <= 16'h0001)
    else $error("busy span wrong");
  a_cfg_needs_cmd: assert property ($changed(cfg) |-> ((cfg == '0 && !init_done) or (##1 $rose(busy))))
    else $error("cfg changed without command");
  a_cfg_hold_busy: assert property (busy && $past(busy) |-> $stable(cfg))
    else $error("cfg changed while busy");
  a_oe_on_read: assert property (s_rd_strobe |=> db_oe)
    else $error("bus not driven on read");
  a_oe_off_idle: assert property (ce_n [*4] |=> !db_oe)
    else $error("bus driven while deselected");
  a_data_read_zero: assert property (!cd_sel [*4] |=> db_out == 8'h00)
    else $error("data read not zero");
  // db_out and busy are launched from the same state sample, so compare them in one cycle
  a_status_ready: assert property (s_idle_status ##0 !busy |-> db_out == 8'h03)
    else $error("status not ready");
  a_status_busy: assert property ((cd_sel && busy) [*4] |-> db_out == 8'h00)
    else $error("status not busy");
  a_init_timing: assert property (init_done |-> timing_running)
    else $error("init done before timing");
  a_shift_runs: assert property ($rose(timing_running) |-> ##[1:1000] $changed(disp.pixel_shift_clock))
    else $error("shift clock idle");
endmodule : lcc_decoder_sva
bind lcc_decoder lcc_decoder_sva #(.OSC_DIV(OSC_DIV)) chk_u (.clk, .rst, .reset_in_low,
  .reset_in_oe, .cd_sel, .ce_n, .rd_n, .db_out, .db_oe, .cfg, .disp, .timing_running,
  .init_done, .busy);
`default_nettype wire

// File: verif/lcc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host processor; released data lines show the inverse, never a stale byte
module lcc_host (
  input  wire logic       clk,
  output logic            cd_sel,
  output logic            ce_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      db_in,
  input  wire logic [7:0] db_out
);
  initial begin
    {cd_sel, ce_n, rd_n, wr_n, db_in} = 12'hf_00;
  end
  // strobes held long enough for the input synchronisers
  task automatic wr(input logic cd, input logic [7:0] b);
    @(posedge clk);
    {cd_sel, ce_n, wr_n, db_in} <= {cd, 2'b00, b};
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (5) @(posedge clk);
    {ce_n, db_in} <= {1'b1, ~b};
  endtask : wr
  task automatic rd(input logic cd, output logic [7:0] b);
    @(posedge clk);
    {cd_sel, ce_n, rd_n} <= {cd, 2'b00};
    repeat (5) @(posedge clk);
    @(negedge clk) b = db_out;
    @(posedge clk);
    {ce_n, rd_n} <= 2'b11;
  endtask : rd
  // bounded status poll before the next command
  task automatic poll();
    logic [7:0] s;
    int         n;
    n = 0;
    do begin
      rd(1'b1, s);
      n++;
    end while (s[0] !== 1'b1 && n < 200);
  endtask : poll
endmodule : lcc_host
`default_nettype wire

// File: verif/tb_lcc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lcc_decoder;
  import lcc_pkg::*;
  localparam int OSC_DIV = 2;  // short oscillator period keeps the run small
  logic         clk, rst, reset_in_low, reset_in_oe, cd_sel, ce_n, rd_n, wr_n, db_oe;
  logic         timing_running, init_done, busy;
  logic [7:0]   db_in, db_out, s;
  lcc_cfg_type  cfg;
  lcc_disp_type disp;
  logic [31:0]  seed = 32'h7a1a;
  int           num_errors = 0, checked = 0, w[7], lo, hi, cs, mg, n;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  lcc_decoder #(.OSC_DIV(OSC_DIV)) dut_u (.clk, .rst, .reset_in_low, .reset_in_oe, .cd_sel,
    .ce_n, .rd_n, .wr_n, .db_in, .db_out, .db_oe, .cfg, .disp, .timing_running, .init_done, .busy);
  lcc_host host_u (.clk, .cd_sel, .ce_n, .rd_n, .wr_n, .db_in, .db_out);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // model: word is last data byte over the one before
  task automatic data(input logic [7:0] b);
    host_u.wr(1'b0, b);
    lo = hi;
    hi = b;
  endtask : data
  task automatic params();
    seed = lfsr(seed);
    data(seed[7:0]);
    seed = lfsr(seed);
    data(seed[15:8]);
  endtask : params
  task automatic cmd(input logic [7:0] b);
    host_u.wr(1'b1, b);
    if (b[7:3] == 5'h04 && b[2:0] inside {3'h1, 3'h2, 3'h4}) w[4 + b[2:0] / 2] = hi * 256 + lo;
    if (b[7:2] == 6'h10) w[b[1:0]] = hi * 256 + lo;
    if (b[7:4] == 4'h8) begin
      cs = b[3];
      mg = b[2:0];
    end
  endtask : cmd
  task automatic check_cfg();
    @(negedge clk);
    check(busy, 1'b0);
    check(cfg, {16'(w[0]), 16'(w[1]), 16'(w[2]), 16'(w[3]), 16'(w[4]), 16'(w[5]), 16'(w[6]),
      1'(cs), 3'(mg)});
  endtask : check_cfg
  task automatic clr();
    foreach (w[i]) w[i] = 0;
    {lo, hi, cs, mg} = '0;
  endtask : clr
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // a hang counts as a mismatch
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  initial begin
    {rst, reset_in_low, reset_in_oe} = 3'b111;
    clr();
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check_cfg();
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      params();
      cmd(8'h40 | 8'(k));
      host_u.rd(1'b1, s);
      check(s, 8'h00);
      host_u.poll();
      check_cfg();
    end
    for (int m = 0; m < 6; m++) begin
      cmd(8'h80 | 8'(m / 3 * 8) | 8'(m % 3 == 2 ? 3 : m % 3));
      host_u.poll();
      check_cfg();
    end
    check({init_done, timing_running}, 2'b11);
    $display("control and mode test done");
    for (int p = 0; p < 5; p++) begin
      params();
      cmd(8'h20 | 8'(p < 3 ? 1 << p : p + 1));
      host_u.poll();
      check_cfg();
    end
    data(8'h5a);
    cmd(8'h21);
    host_u.poll();
    check_cfg();
    params();
    cmd(8'h40);
    host_u.wr(1'b1, 8'h41);
    host_u.poll();
    check_cfg();
    host_u.rd(1'b0, s);
    check(s, 8'h00);
    host_u.rd(1'b1, s);
    check(s, 8'h03);
    $display("pointer and status test done");
    reset_in_low <= 1'b0;
    repeat (6 * OSC_DIV) @(posedge clk);
    reset_in_low <= 1'b1;
    clr();
    repeat (4) @(posedge clk);
    check_cfg();
    check(init_done, 1'b0);
    {reset_in_oe, reset_in_low} <= 2'b00;
    params();
    cmd(8'h42);
    host_u.poll();
    check_cfg();
    $display("pin reset test done");
    // first frame end after the restart: marker, latch and polarity flip together
    for (n = 0; n < 9000 && disp.frame_start_marker !== 1'b1; n++) @(negedge clk);
    check(disp, 4'hd);
    $display("frame test done");
    final_report();
  end
endmodule : tb_lcc_decoder
`default_nettype wire
